/* src/usl_pkg.sv */
// Package for the unit scaling and local/remote select block.
package usl_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_UNIT_SEL     = 12'h000;
  localparam logic [11:0] ADDR_FULL_SCALE   = 12'h004;
  localparam logic [11:0] ADDR_KEY_DISABLE  = 12'h008;
  localparam logic [11:0] ADDR_SRC_CFG      = 12'h00c;
  localparam logic [11:0] ADDR_STATUS       = 12'h010;
  localparam logic [11:0] ADDR_FB_MONITOR   = 12'h014;

  // ----------------------------------------------------------------
  // Field widths, limits and reset values
  // ----------------------------------------------------------------
  localparam int UNIT_W  = 5;
  localparam int SCALE_W = 14;
  localparam int FB_W    = 12;
  localparam logic [4:0]  UNIT_MAX        = 5'h19;
  localparam logic [4:0]  UNIT_FMT        = 5'h00;
  localparam logic [4:0]  UNIT_PERCENT    = 5'h01;
  localparam logic [13:0] SCALE_MIN       = 14'h000a;
  localparam logic [13:0] SCALE_MAX       = 14'h270f;
  localparam logic [13:0] PERCENT_MAX     = 14'h2710;
  localparam logic [4:0]  UNIT_RST        = 5'h00;
  localparam logic [13:0] SCALE_RST       = 14'h0064;
  localparam logic [1:0]  SRC_KEYPAD      = 2'h0;
  localparam logic [FB_W-1:0] FB_FULL     = 12'hfff;

  // Source config register fields.
  localparam int SRC_RUN_LSB  = 0;
  localparam int SRC_FREQ_LSB = 4;
  localparam int SRC_AIN_BIT  = 8;
  localparam int SRC_FMT_LSB  = 12;

  // Display format codes.
  localparam logic [1:0] FMT_EXTERNAL = 2'h0;
  localparam logic [1:0] FMT_PERCENT  = 2'h1;
  localparam logic [1:0] FMT_INTEGER  = 2'h2;

  typedef enum logic [1:0] {
    MODE_IDLE   = 2'b00,
    MODE_REMOTE = 2'b01,
    MODE_LOCAL  = 2'b10
  } usl_mode_e;

  typedef struct packed {
    logic [1:0] run_src;
    logic [1:0] freq_src;
    logic       run_led;
    logic       ref_led;
  } usl_src_s;

  typedef struct packed {
    logic [4:0]  unit_sel;
    logic [13:0] full_scale;
    logic        key_disable;
    logic [1:0]  run_sel;
    logic [1:0]  freq_sel;
    logic        ain_sel;
    logic [3:0]  disp_fmt_cfg;
    usl_mode_e   mode;
    logic        key_prev;
    logic        jog;
    usl_src_s    src;
    logic [1:0]  disp_fmt;
    logic [13:0] disp_max;
    logic [13:0] fb_mon;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } usl_state_s;

endpackage : usl_pkg

/* src/usl_top.sv */
// Unit scaling and local/remote key control with an APB register slave.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - The unit selection register holds codes 0 to 25 and applies to normal and PID use alike.
// - Code 0 lets the frequency display-format setting rule, codes 1 to 25 override it.
// - Code 0 and 1 give a 100.00 maximum for feedback, code 1 showing percent; codes 2 to 25 show integers capped at full scale.
// - Each unit code maps to a fixed unit label, 25 meaning no unit.
// - Full scale is 10 to 9999 and caps every engineering value when the unit code is above 1.
// - The feedback monitor scales the selected analog input and reads zero with PID disabled.
// - Key-disable 0 makes the key a local/remote switch, 1 makes it a jog key.
// - Remote uses the configured sources, local takes both from the keypad.
// - In remote each LED lights for a nonzero source, in local both are dark.
// - With the switch enabled the block starts in remote after reset.
// - A local/remote change is accepted only while the drive is stopped.
// - The switch is disabled when both source selections are zero.
// - Jog is honoured only while stopped with the run source on the keypad.

module usl_top
  import usl_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              key_in,
  input  wire logic              drive_running,
  input  wire logic              pid_enable,
  input  wire logic [FB_W-1:0]   current_analog_input,
  input  wire logic [FB_W-1:0]   voltage_analog_input,
  output logic [1:0]             run_source_select_out,
  output logic [1:0]             frequency_source_select_out,
  output logic                   run_source_indicator,
  output logic                   ref_source_indicator,
  output logic                   jog_request,
  output logic [1:0]             display_format,
  output logic [13:0]            display_max,
  output logic [13:0]            feedback_monitor_value
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // The key and run state come from the panel, so both are retimed.
  logic [1:0] key_sync;
  logic [1:0] run_sync;
  logic [1:0] pid_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_sync <= 2'h0;
      run_sync <= 2'h0;
      pid_sync <= 2'h0;
    end else begin
      key_sync <= {key_sync[0], key_in};
      run_sync <= {run_sync[0], drive_running};
      pid_sync <= {pid_sync[0], pid_enable};
    end
  end
  logic key_s, running_s, pid_s;
  assign key_s     = key_sync[1];
  assign running_s = run_sync[1];
  assign pid_s     = pid_sync[1];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic usl_src_s route_src(input usl_mode_e m, input logic [1:0] rs, input logic [1:0] fs);
    usl_src_s r;
    r = '0;
    if (m == MODE_LOCAL) begin
      r.run_src  = SRC_KEYPAD;
      r.freq_src = SRC_KEYPAD;
    end else begin
      r.run_src  = rs;
      r.freq_src = fs;
      r.run_led  = (rs != SRC_KEYPAD);
      r.ref_led  = (fs != SRC_KEYPAD);
    end
    return r;
  endfunction : route_src

  // Integer scaling of a 12-bit input onto the display range.
  function automatic logic [13:0] scale_fb(input logic [FB_W-1:0] v, input logic [13:0] maxv);
    logic [25:0] p;
    p = 26'(v) * 26'(maxv);
    return 14'(p / 26'(FB_FULL));
  endfunction : scale_fb

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  usl_state_s st_reg, st_next;
  logic       wr_en, rd_en;
  logic       key_rise, switch_ok;
  logic [13:0] cap_max, fb_raw;

  assign wr_en = psel && penable && pwrite && !st_reg.pready;
  assign rd_en = psel && penable && !pwrite && !st_reg.pready;
  assign key_rise = key_s && !st_reg.key_prev;
  // A change while running could swap sources under a live motor.
  assign switch_ok = !st_reg.key_disable && !running_s &&
                     !(st_reg.run_sel == SRC_KEYPAD && st_reg.freq_sel == SRC_KEYPAD);

  always_comb begin
    st_next = st_reg;
    st_next.pready   = 1'b0;
    st_next.pslverr  = 1'b0;
    st_next.key_prev = key_s;

    // Register writes.
    if (wr_en) begin
      st_next.pready = 1'b1;
      case (paddr)
        ADDR_UNIT_SEL: begin
          // The code is kept as written; the panel turns it into its unit label.
          if (pwdata[UNIT_W-1:0] <= UNIT_MAX && pwdata[31:UNIT_W] == '0) begin
            st_next.unit_sel = pwdata[UNIT_W-1:0];
          end else begin
            st_next.pslverr = 1'b1;
          end
        end
        ADDR_FULL_SCALE: begin
          if (pwdata[SCALE_W-1:0] >= SCALE_MIN && pwdata[SCALE_W-1:0] <= SCALE_MAX && pwdata[31:SCALE_W] == '0) begin
            st_next.full_scale = pwdata[SCALE_W-1:0];
          end else begin
            st_next.pslverr = 1'b1;
          end
        end
        ADDR_KEY_DISABLE: st_next.key_disable = pwdata[0];
        ADDR_SRC_CFG: begin
          st_next.run_sel      = pwdata[SRC_RUN_LSB +: 2];
          st_next.freq_sel     = pwdata[SRC_FREQ_LSB +: 2];
          st_next.ain_sel      = pwdata[SRC_AIN_BIT];
          st_next.disp_fmt_cfg = pwdata[SRC_FMT_LSB +: 4];
        end
        ADDR_STATUS, ADDR_FB_MONITOR: st_next.pslverr = 1'b1;
        default: st_next.pslverr = 1'b1;
      endcase
    end

    // Register reads.
    if (rd_en) begin
      st_next.pready = 1'b1;
      case (paddr)
        ADDR_UNIT_SEL:    st_next.prdata = 32'(st_reg.unit_sel);
        ADDR_FULL_SCALE:  st_next.prdata = 32'(st_reg.full_scale);
        ADDR_KEY_DISABLE: st_next.prdata = 32'(st_reg.key_disable);
        ADDR_SRC_CFG:     st_next.prdata = {16'h0000, st_reg.disp_fmt_cfg, 3'h0, st_reg.ain_sel,
                                            2'h0, st_reg.freq_sel, 2'h0, st_reg.run_sel};
        ADDR_STATUS:      st_next.prdata = {26'h0, st_reg.jog, (st_reg.mode == MODE_LOCAL),
                                            st_reg.src.ref_led, st_reg.src.run_led, st_reg.disp_fmt};
        ADDR_FB_MONITOR:  st_next.prdata = 32'(st_reg.fb_mon);
        default: begin
          st_next.prdata  = 32'h0000_0000;
          st_next.pslverr = 1'b1;
        end
      endcase
    end

    // Local/remote key and jog.
    case (st_reg.mode)
      MODE_IDLE: st_next.mode = MODE_REMOTE;
      MODE_REMOTE: begin
        if (key_rise && switch_ok) begin
          st_next.mode = MODE_LOCAL;
        end
      end
      MODE_LOCAL: begin
        if (key_rise && switch_ok) begin
          st_next.mode = MODE_REMOTE;
        end
      end
      default: st_next.mode = MODE_REMOTE;
    endcase
    // With the key disabled it becomes a jog key; a held key keeps jogging.
    // The live setting is used so that re-enabling the switch ends a jog at once.
    st_next.jog = st_next.key_disable && key_s && !running_s &&
                  (st_next.run_sel == SRC_KEYPAD);
    st_next.src = route_src(st_next.mode, st_next.run_sel, st_next.freq_sel);

    // Display format and maximum.
    if (st_next.unit_sel == UNIT_FMT) begin
      st_next.disp_fmt = FMT_EXTERNAL;
      st_next.disp_max = PERCENT_MAX;
    end else if (st_next.unit_sel == UNIT_PERCENT) begin
      st_next.disp_fmt = FMT_PERCENT;
      st_next.disp_max = PERCENT_MAX;
    end else begin
      st_next.disp_fmt = FMT_INTEGER;
      st_next.disp_max = st_next.full_scale;
    end

    // Feedback monitor.
    st_next.fb_mon = pid_s ? fb_raw : 14'h0000;
  end

  assign cap_max = st_reg.disp_max;
  assign fb_raw  = scale_fb(st_reg.ain_sel ? current_analog_input : voltage_analog_input, cap_max);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg            <= '0;
      st_reg.unit_sel   <= UNIT_RST;
      st_reg.full_scale <= SCALE_RST;
      st_reg.mode       <= MODE_IDLE;
      st_reg.disp_max   <= PERCENT_MAX;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pready                      = st_reg.pready;
  assign prdata                      = st_reg.prdata;
  assign pslverr                     = st_reg.pslverr;
  assign run_source_select_out       = st_reg.src.run_src;
  assign frequency_source_select_out = st_reg.src.freq_src;
  assign run_source_indicator        = st_reg.src.run_led;
  assign ref_source_indicator        = st_reg.src.ref_led;
  assign jog_request                 = st_reg.jog;
  assign display_format              = st_reg.disp_fmt;
  assign display_max                 = st_reg.disp_max;
  assign feedback_monitor_value      = st_reg.fb_mon;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_press;
    key_rise && switch_ok;
  endsequence

  sequence s_key_blocked;
    key_rise && (running_s || st_reg.key_disable);
  endsequence

  AST_UNIT_RANGE: assert property (st_reg.unit_sel <= UNIT_MAX)
    else $error("unit selection out of range");
  AST_FMT_EXT: assert property (st_reg.unit_sel == UNIT_FMT |-> display_format == FMT_EXTERNAL)
    else $error("format not external for code zero");
  AST_INT_MAX: assert property (st_reg.unit_sel > UNIT_PERCENT |-> display_max == st_reg.full_scale)
    else $error("integer maximum not full scale");
  AST_SCALE_RANGE: assert property (st_reg.full_scale >= SCALE_MIN && st_reg.full_scale <= SCALE_MAX)
    else $error("full scale out of range");
  AST_FB_ZERO: assert property (!pid_s |=> feedback_monitor_value == 14'h0000)
    else $error("monitor not zero with PID off");
  AST_LOCAL_SRC: assert property (st_reg.mode == MODE_LOCAL |-> run_source_select_out == SRC_KEYPAD
                                  && !run_source_indicator && !ref_source_indicator)
    else $error("local mode not on keypad");
  AST_REMOTE_LED: assert property (st_reg.mode == MODE_REMOTE |-> run_source_indicator == (st_reg.run_sel != SRC_KEYPAD))
    else $error("run LED wrong in remote");
  AST_RESET_REMOTE: assert property ($rose(presetn) |-> ##[1:2] st_reg.mode == MODE_REMOTE)
    else $error("not remote after reset");
  AST_RUN_HOLD: assert property (running_s && key_rise |=> $stable(st_reg.mode))
    else $error("mode changed while running");
  AST_TOGGLE: assert property (s_press and st_reg.mode == MODE_REMOTE |=> st_reg.mode == MODE_LOCAL)
    else $error("press did not toggle mode");
  AST_JOG: assert property (jog_request |-> st_reg.key_disable && st_reg.run_sel == SRC_KEYPAD)
    else $error("jog without permission");
  AST_FMT_PCT: assert property (st_reg.unit_sel == UNIT_PERCENT |-> display_format == FMT_PERCENT)
    else $error("format not percent for code one");
  AST_PCT_MAX: assert property (st_reg.unit_sel <= UNIT_PERCENT |-> display_max == PERCENT_MAX)
    else $error("percent maximum wrong");
  AST_FMT_INT: assert property (st_reg.unit_sel > UNIT_PERCENT |-> display_format == FMT_INTEGER)
    else $error("format not integer for unit codes");
  AST_LOCAL_FREQ: assert property (st_reg.mode == MODE_LOCAL |->
                                   frequency_source_select_out == SRC_KEYPAD)
    else $error("local frequency source not keypad");
  AST_REMOTE_SRC: assert property (st_reg.mode == MODE_REMOTE |-> run_source_select_out == st_reg.run_sel)
    else $error("remote run source wrong");
  AST_REMOTE_FRQ: assert property (st_reg.mode == MODE_REMOTE |->
                                   frequency_source_select_out == st_reg.freq_sel)
    else $error("remote frequency source wrong");
  AST_REMOTE_REF: assert property (st_reg.mode == MODE_REMOTE |->
                                   ref_source_indicator == (st_reg.freq_sel != SRC_KEYPAD))
    else $error("reference LED wrong in remote");
  AST_NO_SOURCES: assert property (key_rise && st_reg.run_sel == SRC_KEYPAD &&
                                   st_reg.freq_sel == SRC_KEYPAD |=> $stable(st_reg.mode))
    else $error("mode changed with both sources on keypad");
  AST_KEY_BLOCKED: assert property (s_key_blocked |=> $stable(st_reg.mode))
    else $error("blocked key changed the mode");
  AST_TOGGLE_BACK: assert property (s_press ##0 st_reg.mode == MODE_LOCAL |=> st_reg.mode == MODE_REMOTE)
    else $error("press did not return to remote");
  AST_JOG_STOP: assert property (jog_request |-> !$past(running_s))
    else $error("jog while running");
  AST_JOG_KEY: assert property (jog_request |-> $past(key_s))
    else $error("jog without a held key");
  // Bus answers are single-cycle pulses, so a held ready would repeat a transfer.
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("ready held for two cycles");
  AST_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_FB_RANGE: assert property (feedback_monitor_value <= $past(display_max))
    else $error("monitor above its maximum");
  AST_IDLE_ONCE: assert property (st_reg.mode == MODE_IDLE |=> st_reg.mode == MODE_REMOTE)
    else $error("mode stuck after reset");

endmodule : usl_top
`default_nettype wire

/* verif/usl_panel.sv */
// Front-panel keypad model that presses the local/remote key.
`timescale 1ns/1ps
`default_nettype none
module usl_panel (
  input  wire logic       pclk,
  input  wire logic       press,
  input  wire logic [3:0] hold,
  output var  logic       key_in
);
  // ------------------------------------------------------------
  // Key press generator
  // ------------------------------------------------------------
  // A press while the key is still high only reloads the hold count, so it gives no new edge.
  logic [3:0] cnt;
  initial begin
    cnt = 4'h0;
    key_in = 1'b0;
  end
  always @(posedge pclk) begin
    if (press) begin
      key_in <= 1'b1;
      cnt    <= hold;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else begin
      key_in <= 1'b0;
    end
  end
endmodule : usl_panel
`default_nettype wire

/* verif/usl_top_bench.sv */
// Self-checking bench for the unit scaling and local/remote block.
`timescale 1ns/1ps
`default_nettype none
module usl_top_bench;
  import usl_pkg::*;
  typedef struct packed {logic rd; logic [31:0] d; logic e;} usl_exp_s;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic             key_in, press, drive_running, pid_enable, run_led, ref_led, jog;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rng, ex;
  logic [3:0]       hold;
  logic [FB_W-1:0]  cur, volt;
  logic [1:0]       run_o, freq_o, fmt;
  logic [13:0]      dmax, fbm, fs;
  int               err_total = 0;
  int               comparisons = 0;
  usl_exp_s         q[$];
  usl_exp_s         e;

  usl_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .key_in, .drive_running, .pid_enable, .current_analog_input(cur), .voltage_analog_input(volt),
    .run_source_select_out(run_o), .frequency_source_select_out(freq_o), .run_source_indicator(run_led),
    .ref_source_indicator(ref_led), .jog_request(jog), .display_format(fmt), .display_max(dmax),
    .feedback_monitor_value(fbm));
  usl_panel panel (.pclk, .press, .hold, .key_in);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // One full APB transfer; the expected answer is queued for the monitor.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
    int n;
    n = 0;
    q.push_back('{!wr && !err, d, err});
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) check(32'h0, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic key(input logic [3:0] h, input int w);
    press <= 1'b1;
    hold  <= h;
    @(posedge pclk);
    press <= 1'b0;
    repeat (w) @(posedge pclk);
  endtask : key

  task automatic outs(input logic [5:0] exp);
    check({26'h0, run_o, freq_o, run_led, ref_led}, {26'h0, exp});
  endtask : outs

  always @(posedge pclk) begin
    if (pready === 1'b1 && q.size() != 0) begin
      e = q.pop_front();
      check({31'h0, pslverr}, {31'h0, e.e});
      if (e.rd) check(prdata, e.d);
    end
  end

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    #400000;
    err_total++;
    wrap_up();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, press, drive_running, pid_enable} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    hold = 4'h0;
    cur = 12'h0;
    volt = 12'h0;
    rng = 32'h6ae566b1;
    repeat (20) @(posedge pclk);
    check({18'h0, dmax}, {18'h0, PERCENT_MAX});
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(0, ADDR_UNIT_SEL, {27'h0, UNIT_RST}, 0);
    apb(0, ADDR_FULL_SCALE, {18'h0, SCALE_RST}, 0);
    rng = xs(rng);
    fs = 14'(rng % 32'd9990) + SCALE_MIN;
    for (int u = 0; u <= 25; u++) begin
      apb(1, ADDR_UNIT_SEL, 32'(u), 0);
      apb(1, ADDR_FULL_SCALE, {18'h0, fs}, 0);
      check({30'h0, fmt}, u == 0 ? 32'(FMT_EXTERNAL) : u == 1 ? 32'(FMT_PERCENT) : 32'(FMT_INTEGER));
      check({18'h0, dmax}, u < 2 ? {18'h0, PERCENT_MAX} : {18'h0, fs});
      apb(0, ADDR_UNIT_SEL, 32'(u), 0);
    end
    apb(1, ADDR_UNIT_SEL, 32'd26, 1);
    apb(1, ADDR_UNIT_SEL, 32'h20, 1);
    apb(0, ADDR_UNIT_SEL, 32'd25, 0);
    apb(1, ADDR_FULL_SCALE, 32'd9, 1);
    apb(1, ADDR_FULL_SCALE, 32'd10000, 1);
    apb(1, ADDR_FULL_SCALE, 32'd10, 0);
    check({18'h0, dmax}, 32'd10);
    apb(1, ADDR_FULL_SCALE, 32'd9999, 0);
    apb(1, ADDR_SRC_CFG, 32'h3121, 0);
    apb(0, ADDR_SRC_CFG, 32'h3121, 0);
    apb(1, ADDR_STATUS, 32'h0, 1);
    apb(0, 12'h040, 32'h0, 1);
    pid_enable <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      rng = xs(rng);
      cur  <= rng[11:0];
      volt <= rng[27:16];
      apb(1, ADDR_SRC_CFG, 32'h21 | (32'(s) << SRC_AIN_BIT), 0);
      repeat (8) @(posedge pclk);
      ex = 32'(s == 1 ? cur : volt) * 32'(SCALE_MAX) / 32'd4095;
      check({18'h0, fbm}, ex);
      apb(0, ADDR_FB_MONITOR, ex, 0);
    end
    pid_enable <= 1'b0;
    repeat (8) @(posedge pclk);
    check({18'h0, fbm}, 32'h0);
    outs(6'b01_10_1_1);
    apb(1, ADDR_KEY_DISABLE, 32'h0, 0);
    key(4'h2, 12);
    outs(6'b00_00_0_0);
    apb(0, ADDR_STATUS, 32'h12, 0);
    key(4'h9, 20);
    outs(6'b01_10_1_1);
    drive_running <= 1'b1;
    repeat (6) @(posedge pclk);
    key(4'h2, 12);
    outs(6'b01_10_1_1);
    drive_running <= 1'b0;
    apb(1, ADDR_SRC_CFG, 32'h20, 0);
    outs(6'b00_10_0_1);
    apb(1, ADDR_SRC_CFG, 32'h0, 0);
    key(4'h2, 12);
    apb(1, ADDR_SRC_CFG, 32'h21, 0);
    outs(6'b01_10_1_1);
    apb(1, ADDR_KEY_DISABLE, 32'h1, 0);
    apb(0, ADDR_KEY_DISABLE, 32'h1, 0);
    for (int j = 0; j < 3; j++) begin
      drive_running <= (j == 1);
      apb(1, ADDR_SRC_CFG, j == 2 ? 32'h21 : 32'h20, 0);
      repeat (6) @(posedge pclk);
      key(4'hf, 8);
      check({31'h0, jog}, {31'h0, j == 0});
      repeat (14) @(posedge pclk);
    end
    check({31'h0, jog}, 32'h0);
    outs(6'b01_10_1_1);
    wrap_up();
  end
endmodule : usl_top_bench
`default_nettype wire
